/* design/hjd_top.sv */
`timescale 1ns/1ps
`include "hjd_defs.svh"

module hjd_top #(
    parameter int unsigned MS_CYCLES = `HJD_MS_NS / `HJD_CLK_PERIOD_NS
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input hjd_pkg::hjd_sense_t sense,
    output hjd_pkg::hjd_drive_t drive,
    output logic irq
);
    import hjd_pkg::*;

    localparam logic [17:0] MS_LAST = 18'(MS_CYCLES - 1);

    logic [7:0] mon_q, ctl_q, deb_q, aux_q;
    logic [3:0] irq_st_q, irq_en_q;
    logic [1:0] jack_type_q, set_kind_status_q, tick_cnt_q, cand_cnt_q, hook_cnt_q;
    hjd_state_t state_q;
    logic [17:0] ms_cnt_q;
    logic [10:0] rate_cnt_q;
    logic [9:0] ins_ms_q;
    logic [2:0] rem_cnt_q, cand_q;
    logic ms_tick_q, pulse_q, tick_q, raw_jack_q, hook_q, pready_q, pslverr_q, irq_q;
    logic [31:0] prdata_q;
    hjd_drive_t drive_q;

    logic detect_on, smp, smp_in, wr_en, rd_hit;
    logic ins_accept, rem_accept, kind_accept, hook_rise;
    logic [7:0] idx, rd_data;
    logic [10:0] rate_last;
    logic [9:0] ins_target;
    logic [2:0] rem_need, new_kind;
    logic [1:0] tick_last, phone_need, button_need, match_cnt, hook_next;
    logic [3:0] events, irq_clr;

    assign idx = {2'b00, paddr[7:2]};
    assign detect_on = ctl_q[`HJD_CTL_ON];
    assign smp = sense.valid && detect_on && (state_q != HJD_OFF);
    assign smp_in = smp && (state_q == HJD_INSERTED);
    assign wr_en = psel && penable && pwrite && pready_q;

    // Debounce and rate decodes
    always_comb begin
        case (mon_q[`HJD_MON_RATE])
            2'd0: rate_last = `HJD_RATE0_MS - 11'd1;
            2'd1: rate_last = `HJD_RATE1_MS - 11'd1;
            2'd2: rate_last = `HJD_RATE2_MS - 11'd1;
            default: rate_last = `HJD_RATE3_MS - 11'd1;
        endcase
        case (mon_q[`HJD_MON_TICK])
            2'd0: tick_last = 2'd0;
            2'd1: tick_last = 2'd1;
            // Reserved code kept at the slowest period
            default: tick_last = 2'd3;
        endcase
        case (deb_q[`HJD_DEB_INSERT])
            3'd0: ins_target = `HJD_INS0_MS;
            3'd1: ins_target = `HJD_INS1_MS;
            3'd2: ins_target = `HJD_INS2_MS;
            3'd3: ins_target = `HJD_INS3_MS;
            3'd4: ins_target = `HJD_INS4_MS;
            // Reserved code 6 treated as the longest time
            default: ins_target = `HJD_INS5_MS;
        endcase
        rem_need = deb_q[`HJD_DEB_REMOVAL] ? 3'd3 : 3'd5;
        phone_need = deb_q[`HJD_DEB_PHONE] ? 2'd3 : 2'd1;
        case (deb_q[`HJD_DEB_BUTTON])
            2'd2: button_need = 2'd2;
            2'd3: button_need = 2'd3;
            default: button_need = 2'd1;
        endcase
    end

    // Acceptance decisions
    always_comb begin
        new_kind = {sense.mic, sense.kind};
        match_cnt = (new_kind == cand_q && cand_cnt_q != 2'd3) ? cand_cnt_q + 2'd1 :
                    (new_kind == cand_q) ? 2'd3 : 2'd1;
        ins_accept = 1'b0;
        if (state_q == HJD_ARMED) begin
            if (deb_q[`HJD_DEB_INSERT] == 3'd7) begin
                ins_accept = smp && sense.jack;
            end else begin
                ins_accept = raw_jack_q && (ins_ms_q >= ins_target);
            end
        end
        rem_accept = smp_in && !sense.jack && (rem_cnt_q + 3'd1 >= rem_need);
        kind_accept = smp_in && sense.jack && (match_cnt >= phone_need) &&
                      ({jack_type_q[1], set_kind_status_q} != new_kind);
        hook_next = (hook_cnt_q == 2'd3) ? 2'd3 : hook_cnt_q + 2'd1;
        hook_rise = smp_in && sense.jack && sense.hook && !hook_q &&
                    (hook_next >= button_need);
        events = {hook_rise, kind_accept, rem_accept, ins_accept};
        irq_clr = (wr_en && idx == `HJD_IDX_IRQ_CLEAR) ? pwdata[3:0] : 4'h0;
    end

    // Millisecond base enable
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ms_cnt_q <= 18'h0;
            ms_tick_q <= 1'b0;
        end else if (!detect_on) begin
            ms_cnt_q <= 18'h0;
            ms_tick_q <= 1'b0;
        end else if (ms_cnt_q >= MS_LAST) begin
            ms_cnt_q <= 18'h0;
            ms_tick_q <= 1'b1;
        end else begin
            ms_cnt_q <= ms_cnt_q + 18'h1;
            ms_tick_q <= 1'b0;
        end
    end

    // Detection pulse repetition
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rate_cnt_q <= 11'h0;
            pulse_q <= 1'b0;
        end else if (!detect_on) begin
            rate_cnt_q <= 11'h0;
            pulse_q <= 1'b0;
        end else if (ms_tick_q && rate_cnt_q >= rate_last) begin
            rate_cnt_q <= 11'h0;
            pulse_q <= 1'b1;
        end else begin
            if (ms_tick_q) begin
                rate_cnt_q <= rate_cnt_q + 11'h1;
            end
            pulse_q <= 1'b0;
        end
    end

    // Headphone detection tick
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_q <= 2'h0;
            tick_q <= 1'b0;
        end else if (!detect_on) begin
            tick_cnt_q <= 2'h0;
            tick_q <= 1'b0;
        end else if (ms_tick_q && tick_cnt_q >= tick_last) begin
            tick_cnt_q <= 2'h0;
            tick_q <= 1'b1;
        end else begin
            if (ms_tick_q) begin
                tick_cnt_q <= tick_cnt_q + 2'h1;
            end
            tick_q <= 1'b0;
        end
    end

    // Detection state
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= HJD_OFF;
        end else begin
            case (state_q)
                HJD_OFF: begin
                    if (detect_on) begin
                        state_q <= HJD_ARMED;
                    end
                end
                HJD_ARMED: begin
                    if (!detect_on) begin
                        state_q <= HJD_OFF;
                    end else if (ins_accept) begin
                        state_q <= HJD_INSERTED;
                    end
                end
                HJD_INSERTED: begin
                    if (!detect_on) begin
                        state_q <= HJD_OFF;
                    end else if (rem_accept) begin
                        state_q <= HJD_ARMED;
                    end
                end
                default: state_q <= HJD_OFF;
            endcase
        end
    end

    // Insertion timing, restarted by any absent sample
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            raw_jack_q <= 1'b0;
            ins_ms_q <= 10'h0;
        end else if (state_q != HJD_ARMED || ins_accept) begin
            raw_jack_q <= 1'b0;
            ins_ms_q <= 10'h0;
        end else if (smp && !sense.jack) begin
            raw_jack_q <= 1'b0;
            ins_ms_q <= 10'h0;
        end else begin
            if (smp) begin
                raw_jack_q <= 1'b1;
            end
            if (ms_tick_q && raw_jack_q && ins_ms_q != 10'h3FF) begin
                ins_ms_q <= ins_ms_q + 10'h1;
            end
        end
    end

    // Removal count of successive absent samples
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rem_cnt_q <= 3'h0;
        end else if (state_q != HJD_INSERTED || rem_accept) begin
            rem_cnt_q <= 3'h0;
        end else if (smp_in) begin
            rem_cnt_q <= sense.jack ? 3'h0 : rem_cnt_q + 3'h1;
        end
    end

    // Type candidate tracking
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cand_q <= 3'h0;
            cand_cnt_q <= 2'h0;
        end else if (state_q != HJD_INSERTED) begin
            cand_q <= 3'h0;
            cand_cnt_q <= 2'h0;
        end else if (smp_in && sense.jack) begin
            cand_q <= new_kind;
            cand_cnt_q <= match_cnt;
        end
    end

    // Hook press detection
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            hook_cnt_q <= 2'h0;
            hook_q <= 1'b0;
        end else if (state_q != HJD_INSERTED) begin
            hook_cnt_q <= 2'h0;
            hook_q <= 1'b0;
        end else if (smp_in) begin
            if (sense.jack && sense.hook) begin
                hook_cnt_q <= hook_next;
                if (hook_rise) begin
                    hook_q <= 1'b1;
                end
            end else begin
                hook_cnt_q <= 2'h0;
                hook_q <= 1'b0;
            end
        end
    end

    // Reported jack and headset type
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            jack_type_q <= 2'b00;
            set_kind_status_q <= 2'b00;
        end else if (state_q == HJD_OFF || rem_accept) begin
            jack_type_q <= 2'b00;
            set_kind_status_q <= 2'b00;
        end else if (kind_accept) begin
            // Only debounced results reach the status
            jack_type_q <= sense.mic ? 2'b11 : 2'b01;
            set_kind_status_q <= sense.kind;
        end
    end

    // Configuration registers; reserved bits are never stored
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mon_q <= `HJD_RST_REG;
            ctl_q <= `HJD_RST_REG;
            deb_q <= `HJD_RST_REG;
            aux_q <= `HJD_RST_REG;
            irq_en_q <= `HJD_RST_IRQ;
        end else if (wr_en) begin
            case (idx)
                `HJD_IDX_MONITOR: mon_q <= pwdata[7:0] & `HJD_MASK_MONITOR;
                `HJD_IDX_CONTROL: ctl_q <= pwdata[7:0] & `HJD_MASK_CONTROL;
                `HJD_IDX_DEBOUNCE: deb_q <= pwdata[7:0] & `HJD_MASK_DEBOUNCE;
                `HJD_IDX_AUX: aux_q <= pwdata[7:0] & `HJD_MASK_AUX;
                `HJD_IDX_IRQ_ENABLE: irq_en_q <= pwdata[3:0];
                default: irq_en_q <= irq_en_q;
            endcase
        end
    end

    // Sticky events; a new event beats a clear in the same cycle
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_st_q <= `HJD_RST_IRQ;
            irq_q <= 1'b0;
        end else begin
            irq_st_q <= (irq_st_q & ~irq_clr) | events;
            irq_q <= |(irq_st_q & irq_en_q);
        end
    end

    // Read decode
    always_comb begin
        rd_hit = 1'b1;
        case (idx)
            `HJD_IDX_MONITOR: rd_data = mon_q;
            `HJD_IDX_CONTROL: rd_data = ctl_q;
            `HJD_IDX_DEBOUNCE: rd_data = deb_q;
            `HJD_IDX_RESULT: rd_data = {jack_type_q, set_kind_status_q, 4'h0};
            `HJD_IDX_AUX: rd_data = aux_q;
            `HJD_IDX_IRQ_STATUS: rd_data = {4'h0, irq_st_q};
            `HJD_IDX_IRQ_CLEAR: rd_data = 8'h00;
            `HJD_IDX_IRQ_ENABLE: rd_data = {4'h0, irq_en_q};
            default: begin
                rd_data = 8'h00;
                rd_hit = 1'b0;
            end
        endcase
    end

    // One wait state keeps every bus output registered
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0;
        end else if (psel && penable && !pready_q) begin
            pready_q <= 1'b1;
            pslverr_q <= !rd_hit;
            prdata_q <= pwrite ? 32'h0 : {24'h0, rd_data};
        end else begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    // Front-end controls
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            drive_q <= '0;
        end else begin
            drive_q.detect_on <= detect_on && state_q != HJD_OFF;
            // A pulse launched just before a disable must not reach the front end
            drive_q.pulse <= pulse_q && detect_on && state_q != HJD_OFF;
            drive_q.pulse_wide <= mon_q[`HJD_MON_WIDTH];
            drive_q.hp_tick <= tick_q;
            drive_q.double_current <= ctl_q[`HJD_CTL_DOUBLE];
            drive_q.coupling_dc <= ctl_q[`HJD_CTL_COUPLING];
            drive_q.hook_cfg <= ctl_q[`HJD_CTL_COMP2];
            // Threshold only applies with the resistor type bit clear
            if (aux_q[`HJD_AUX_EXTRES] || ctl_q[`HJD_CTL_THR] == 2'd3) begin
                drive_q.hook_thr <= 2'd0;
            end else begin
                drive_q.hook_thr <= ctl_q[`HJD_CTL_THR];
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign drive = drive_q;
    assign irq = irq_q;

endmodule : hjd_top

/* pkg/hjd_defs.svh */
// Summary of operation
// - Detection runs only while the detection enable bit is set and stays idle otherwise.
// - The double-current bit selects twice the normal sense current for headphone detection.
// - The hook insertion threshold selects 150, 100 or 50 ohm for codes 0-2, with 3 reserved.
// - Headphone debounce bit zero means no debounce; one needs 3 equal results in a row.
// - Insertion debounce codes 0-5 select 16 to 512 ms, 6 is reserved and 7 means none.
// - Removal is accepted after 5 absent detections in a row, or after 3 when the bit is one.
// - Hook debounce codes 0 and 1 mean none, code 2 needs 2 detections and code 3 needs 3.
// - Jack type at bits 7-6 reads 0 with no jack, 1 without mic, 3 with mic, never 2.
// - Headset type at bits 5-4 reads 0 none, 1 mono right, 2 mono left, 3 stereo.
// - Detection pulses repeat at 0.5, 1, 7.5 or 15 Hz for rate codes 0 to 3.
// - The headphone detection tick period is 1, 2 or 4 ms for codes 0 to 2, 3 reserved.
`ifndef HJD_DEFS_SVH
`define HJD_DEFS_SVH

// Register indices; byte address is four times the index
`define HJD_IDX_MONITOR 8'h19
`define HJD_IDX_CONTROL 8'h1A
`define HJD_IDX_DEBOUNCE 8'h1B
`define HJD_IDX_RESULT 8'h1C
`define HJD_IDX_AUX 8'h1D
`define HJD_IDX_IRQ_STATUS 8'h20
`define HJD_IDX_IRQ_CLEAR 8'h21
`define HJD_IDX_IRQ_ENABLE 8'h22

`define HJD_RST_REG 8'h00
`define HJD_RST_IRQ 4'h0
`define HJD_MASK_MONITOR 8'hE6
`define HJD_MASK_CONTROL 8'h7E
`define HJD_MASK_DEBOUNCE 8'h7F
`define HJD_MASK_AUX 8'h01

// Field positions
`define HJD_MON_RATE 7:6
`define HJD_MON_WIDTH 5
`define HJD_MON_TICK 2:1
`define HJD_CTL_COMP2 6
`define HJD_CTL_THR 5:4
`define HJD_CTL_COUPLING 3
`define HJD_CTL_DOUBLE 2
`define HJD_CTL_ON 1
`define HJD_DEB_PHONE 6
`define HJD_DEB_INSERT 5:3
`define HJD_DEB_REMOVAL 2
`define HJD_DEB_BUTTON 1:0
`define HJD_AUX_EXTRES 0

// Timing
`define HJD_CLK_PERIOD_NS 4
`define HJD_MS_NS 1000000
`define HJD_RATE0_MS 11'd2000
`define HJD_RATE1_MS 11'd1000
`define HJD_RATE2_MS 11'd133
`define HJD_RATE3_MS 11'd66
`define HJD_INS0_MS 10'd16
`define HJD_INS1_MS 10'd32
`define HJD_INS2_MS 10'd64
`define HJD_INS3_MS 10'd128
`define HJD_INS4_MS 10'd256
`define HJD_INS5_MS 10'd512

`endif

/* pkg/hjd_pkg.sv */
package hjd_pkg;

    // Result of one analog detection measurement
    typedef struct packed {
        logic valid;
        logic jack;
        logic mic;
        logic [1:0] kind;
        logic hook;
    } hjd_sense_t;

    // Controls towards the analog front end
    typedef struct packed {
        logic detect_on;
        logic pulse;
        logic pulse_wide;
        logic hp_tick;
        logic double_current;
        logic coupling_dc;
        logic hook_cfg;
        logic [1:0] hook_thr;
    } hjd_drive_t;

    typedef enum logic [1:0] {
        HJD_OFF = 2'b00,
        HJD_ARMED = 2'b01,
        HJD_INSERTED = 2'b11
    } hjd_state_t;

endpackage : hjd_pkg

/* dv/hjd_top_properties.sv */
`timescale 1ns/1ps
`include "hjd_defs.svh"

module hjd_top_properties #(
    parameter int unsigned MS_CYCLES = 4
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input hjd_pkg::hjd_sense_t sense,
    input hjd_pkg::hjd_drive_t drive,
    input wire logic irq
);
    import hjd_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic acc_done;
    logic rd_res;
    logic wr_ctl;
    assign acc_done = psel && penable && pready;
    assign rd_res = acc_done && !pwrite && paddr[7:2] == 6'(`HJD_IDX_RESULT);
    assign wr_ctl = acc_done && pwrite && paddr[7:2] == 6'(`HJD_IDX_CONTROL);

    // Enable needs one extra cycle for the state to leave off
    AST_ON_FOLLOWS: assert property (wr_ctl |->
        ##3 drive.detect_on == $past(pwdata[1], 3))
        else $error("detect enable does not follow control write");
    AST_PULSE_GATED: assert property (drive.pulse |-> drive.detect_on)
        else $error("detection pulse while disabled");
    AST_DOUBLE: assert property (wr_ctl |->
        ##2 drive.double_current == $past(pwdata[2], 2))
        else $error("sense current select does not follow control write");
    AST_THR_NOT_RSVD: assert property (drive.hook_thr != 2'h3)
        else $error("reserved hook threshold driven");
    AST_PULSE_ONE: assert property (drive.pulse |=> !drive.pulse)
        else $error("detection pulse longer than one cycle");
    AST_TICK_SPACE: assert property (drive.hp_tick |=> !drive.hp_tick [*3])
        else $error("detect ticks closer than one ms");
    AST_NO_CODE2: assert property (rd_res |-> prdata[7:6] != 2'h2)
        else $error("jack type reads unused code");
    AST_TYPE_PAIR: assert property (rd_res && prdata[7:6] == 2'h0 |->
        prdata[5:4] == 2'h0)
        else $error("headset type set with no jack");
    AST_RSVD_ZERO: assert property (acc_done && !pwrite |->
        prdata[31:8] == 24'h0 && (!rd_res || prdata[3:0] == 4'h0))
        else $error("reserved read bits not zero");
    AST_RESET_CLEAR: assert property ($rose(rst_n) |-> drive == '0 && !irq)
        else $error("outputs not clear after reset");

    cover property (rd_res && prdata[7:6] == 2'h3);
    cover property (acc_done && pslverr);
    cover property (irq);
endmodule : hjd_top_properties

bind hjd_top hjd_top_properties #(.MS_CYCLES(MS_CYCLES)) hjd_top_properties_inst (
    .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sense(sense), .drive(drive), .irq(irq));

/* dv/hjd_sense_model.sv */
`timescale 1ns/1ps

module hjd_sense_model (
    input wire logic core_clk,
    input wire logic rst_n,
    input hjd_pkg::hjd_drive_t drive,
    input wire logic jack,
    input wire logic mic,
    input wire logic [1:0] kind,
    input wire logic hook,
    input wire logic slow,
    output hjd_pkg::hjd_sense_t sense
);
    import hjd_pkg::*;
    logic [3:0] wait_q;
    // Slow answer mimics a large bias capacitor settling
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_q <= 4'h0;
        end else if (drive.pulse && drive.detect_on) begin
            wait_q <= slow ? 4'h7 : 4'h1;
        end else if (wait_q != 4'h0) begin
            wait_q <= wait_q - 4'h1;
        end
    end
    // Fields toggle outside a result so stale values cannot pass
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sense <= '0;
        end else if (wait_q == 4'h1) begin
            sense <= {1'h1, jack, mic, kind, hook};
        end else begin
            sense <= {1'h0, ~sense[4:0]};
        end
    end
endmodule : hjd_sense_model

/* dv/test_headset_jack_detect_debounce.sv */
`timescale 1ns/1ps
`include "hjd_defs.svh"

module test_headset_jack_detect_debounce;
    import hjd_pkg::*;
    localparam int unsigned MS = 4;
    localparam logic [7:0] IDX [7] = '{`HJD_IDX_MONITOR, `HJD_IDX_CONTROL, `HJD_IDX_DEBOUNCE,
        `HJD_IDX_RESULT, `HJD_IDX_AUX, `HJD_IDX_IRQ_CLEAR, `HJD_IDX_IRQ_ENABLE};
    localparam logic [7:0] WV [7] = '{`HJD_MASK_MONITOR, `HJD_MASK_CONTROL, `HJD_MASK_DEBOUNCE,
        8'hF0, `HJD_MASK_AUX, 8'h0F, 8'h0F};
    localparam logic [7:0] RV [7] = '{`HJD_MASK_MONITOR, `HJD_MASK_CONTROL, `HJD_MASK_DEBOUNCE,
        8'h00, `HJD_MASK_AUX, 8'h00, 8'h0F};
    localparam int INS_N [8] = '{2, 2, 2, 3, 5, 9, 9, 1};
    localparam int RATE_MS [4] = '{2000, 1000, 133, 66};
    localparam int TICK_MS [4] = '{1, 2, 4, 4};
    localparam int HOOK_N [4] = '{1, 1, 2, 3};
    logic core_clk = 1'h0;
    logic rst_n = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    hjd_sense_t sense;
    hjd_drive_t drive;
    logic irq;
    logic m_jack = 1'h0;
    logic m_hook = 1'h0;
    logic m_slow = 1'h0;
    logic [2:0] m_mk = 3'h7;
    logic [31:0] r;
    logic e;
    int err_total = 0;
    int n_tests = 0;

    hjd_top #(.MS_CYCLES(MS)) hjd_top_inst (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sense(sense), .drive(drive), .irq(irq));
    hjd_sense_model hjd_sense_model_inst (.core_clk(core_clk), .rst_n(rst_n), .drive(drive),
        .jack(m_jack), .mic(m_mk[2]), .kind(m_mk[1:0]), .hook(m_hook), .slow(m_slow),
        .sense(sense));

    initial begin
        forever #2 core_clk = ~core_clk;
    end

    task automatic close_out();
        if (err_total == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : close_out

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    function automatic logic pick(input int sel);
        case (sel)
            0: return pready;
            1: return sense.valid;
            2: return drive.pulse;
            default: return drive.hp_tick;
        endcase
    endfunction : pick

    task automatic wait_on(input int sel, output int k);
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (pick(sel) !== 1'h1 && k < 40000);
        if (k >= 40000) begin
            err_total++;
            close_out();
        end
    endtask : wait_on

    task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] d);
        int k;
        psel <= 1'h1;
        pwrite <= w;
        paddr <= 8'(idx * 4);
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'h1;
        wait_on(0, k);
        r = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge core_clk);
    endtask : xfer

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        xfer(1'h1, idx, d);
    endtask : wr

    task automatic rd_chk(input string nm, input logic [7:0] idx, input logic [31:0] exp);
        xfer(1'h0, idx, 32'h0);
        chk(nm, r, exp);
    endtask : rd_chk

    task automatic samp(input int n);
        int k;
        repeat (n) wait_on(1, k);
        repeat (3) @(posedge core_clk);
    endtask : samp

    // One insert, type report and removal with the given debounce setting
    task automatic cyc(input logic [31:0] deb, input logic [2:0] mk, input int ins_n,
        input int type_n, input int rem_n, input logic [31:0] exp);
        wr(`HJD_IDX_DEBOUNCE, deb);
        wr(`HJD_IDX_IRQ_CLEAR, 32'hF);
        m_mk <= mk;
        m_jack <= 1'h1;
        samp(ins_n - 1);
        rd_chk("insert early", `HJD_IDX_IRQ_STATUS, 32'h0);
        // A timed insert ends between samples, so the next sample reports the type too
        if (type_n == 0) begin
            rd_chk("type early", `HJD_IDX_RESULT, 32'h0);
        end
        samp(1);
        rd_chk("insert event", `HJD_IDX_IRQ_STATUS, (type_n == 0) ? 32'h5 : 32'h1);
        if (type_n > 0) begin
            samp(type_n - 1);
            rd_chk("type early", `HJD_IDX_RESULT, 32'h0);
            samp(1);
        end
        rd_chk("type", `HJD_IDX_RESULT, exp);
        m_jack <= 1'h0;
        samp(rem_n - 1);
        rd_chk("remove early", `HJD_IDX_RESULT, exp);
        samp(1);
        rd_chk("remove", `HJD_IDX_RESULT, 32'h0);
    endtask : cyc

    initial begin
        int k;
        repeat (16) @(posedge core_clk);
        rst_n <= 1'h1;
        @(posedge core_clk);
        rd_chk("reset status", `HJD_IDX_IRQ_STATUS, 32'h0);
        for (int i = 0; i < 7; i++) begin
            rd_chk("reset value", IDX[i], 32'h0);
            wr(IDX[i], {24'h0, WV[i]});
            rd_chk("read back", IDX[i], {24'h0, RV[i]});
        end
        xfer(1'h0, 8'h30, 32'h0);
        chk("unmapped read err", e, 32'h1);
        chk("unmapped read data", r, 32'h0);
        wr(8'h30, 32'h0);
        chk("unmapped write err", e, 32'h1);
        wr(`HJD_IDX_AUX, 32'h0);
        for (int c = 0; c < 4; c++) begin
            wr(`HJD_IDX_CONTROL, c * 16 + (c % 2) * 4);
            repeat (3) @(posedge core_clk);
            chk("threshold", drive.hook_thr, (c == 3) ? 0 : c);
            chk("double current", drive.double_current, c % 2);
        end
        wr(`HJD_IDX_AUX, 32'h1);
        wr(`HJD_IDX_CONTROL, 32'h58);
        repeat (3) @(posedge core_clk);
        chk("threshold unused", drive.hook_thr, 32'h0);
        chk("coupling", drive.coupling_dc, 32'h1);
        chk("hook config", drive.hook_cfg, 32'h1);
        wr(`HJD_IDX_CONTROL, 32'h0);
        wr(`HJD_IDX_MONITOR, 32'hE0);
        k = 0;
        repeat (600) begin
            @(posedge core_clk);
            k += (drive.pulse !== 1'h0);
        end
        chk("idle pulses", k, 32'h0);
        chk("pulse width", drive.pulse_wide, 32'h1);
        wr(`HJD_IDX_CONTROL, 32'h2);
        for (int c = 0; c < 4; c++) begin
            wr(`HJD_IDX_MONITOR, c * 64 + c * 2);
            repeat (2) wait_on(2, k);
            chk("pulse gap", k, RATE_MS[c] * MS);
            repeat (2) wait_on(3, k);
            chk("tick gap", k, TICK_MS[c] * MS);
        end
        wr(`HJD_IDX_IRQ_ENABLE, 32'hF);
        for (int i = 0; i < 8; i++) begin
            cyc(i * 8, 3'h7, INS_N[i], (i == 7) ? 1 : 0, 5, 32'hF0);
        end
        m_slow <= 1'h1;
        cyc(32'h3C, 3'h1, 1, 1, 3, 32'h50);
        cyc(32'h78, 3'h2, 1, 3, 5, 32'h60);
        cyc(32'h38, 3'h3, 1, 1, 5, 32'h70);
        m_slow <= 1'h0;
        wr(`HJD_IDX_IRQ_CLEAR, 32'hF);
        m_mk <= 3'h7;
        m_jack <= 1'h1;
        samp(2);
        chk("irq raised", irq, 32'h1);
        wr(`HJD_IDX_IRQ_ENABLE, 32'h0);
        @(posedge core_clk);
        chk("irq masked", irq, 32'h0);
        wr(`HJD_IDX_IRQ_ENABLE, 32'hF);
        @(posedge core_clk);
        chk("irq unmasked", irq, 32'h1);
        rd_chk("status", `HJD_IDX_IRQ_STATUS, 32'h5);
        wr(`HJD_IDX_IRQ_CLEAR, 32'hF);
        @(posedge core_clk);
        chk("irq cleared", irq, 32'h0);
        rd_chk("status cleared", `HJD_IDX_IRQ_STATUS, 32'h0);
        for (int b = 0; b < 4; b++) begin
            wr(`HJD_IDX_DEBOUNCE, 32'h38 + b);
            wr(`HJD_IDX_IRQ_CLEAR, 32'hF);
            m_hook <= 1'h1;
            samp(HOOK_N[b] - 1);
            xfer(1'h0, `HJD_IDX_IRQ_STATUS, 32'h0);
            chk("hook early", r & 32'h8, 32'h0);
            samp(1);
            xfer(1'h0, `HJD_IDX_IRQ_STATUS, 32'h0);
            chk("hook", r & 32'h8, 32'h8);
            m_hook <= 1'h0;
            samp(1);
        end
        rst_n <= 1'h0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'h1;
        @(posedge core_clk);
        rd_chk("result after reset", `HJD_IDX_RESULT, 32'h0);
        rd_chk("control after reset", `HJD_IDX_CONTROL, 32'h0);
        close_out();
    end
endmodule : test_headset_jack_detect_debounce
